//--- src/dcp_drive_param.v
// cyclic drive words: parameter access area and basic profile state machine
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "dcp_map.vh"
module dcp_drive_param #(
  parameter IW = 4,
  parameter DEPTH = `DCP_PARAM_DEPTH
) (
  input wire clk_sys, // system clock 100 MHz
  input wire sys_rst, // synchronous reset, high
  input wire [3:0] avs_address, // word address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  input wire [3:0] avs_byteenable, // byte lanes
  output reg [31:0] avs_readdata, // read data
  output reg avs_waitrequest, // stall, low one cycle per access
  input wire rx_valid, // new cyclic frame from fieldbus
  input wire [15:0] rx_param_address_word, // request word one
  input wire [15:0] rx_req_code, // request word two
  input wire [15:0] rx_param_value_word_hi, // request word three
  input wire [15:0] rx_param_value_word_lo, // request word four
  input wire [15:0] rx_command_word, // profile command
  input wire [15:0] rx_speed_reference_word, // profile reference
  output reg [15:0] tx_param_address_word, // response word one
  output reg [15:0] tx_resp_code, // response word two
  output reg [15:0] tx_param_value_word_hi, // response word three
  output reg [15:0] tx_param_value_word_lo, // response word four
  output reg [15:0] tx_operating_state_word, // profile state
  output reg [15:0] tx_actual_velocity_word, // profile velocity
  input wire drive_fault_in, // asynchronous fault pin, high
  output reg run_enable, // power stage enabled
  output reg [15:0] speed_setpoint // reference to speed loop
);
  localparam PA_IDLE = 4'b0001;
  localparam PA_BUSY = 4'b0010;
  localparam PA_WAIT = 4'b0100;
  localparam PA_DONE = 4'b1000;
  localparam DS_INHIB = 5'b00001;
  localparam DS_READY = 5'b00010;
  localparam DS_SWON = 5'b00100;
  localparam DS_OPEN = 5'b01000;
  localparam DS_FAULT = 5'b10000;

  function param_tel;
    input [15:0] t;
    begin
      param_tel = (t == `DCP_TEL_P100) || (t == `DCP_TEL_P101) || (t == `DCP_TEL_P102) ||
                  (t == `DCP_TEL_P106) || (t == `DCP_TEL_P107);
    end
  endfunction

  function [31:0] merge_be;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer k;
    begin
      merge_be = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge_be[k*8 +: 8] = wd[k*8 +: 8];
        end
      end
    end
  endfunction

  reg [15:0] tel_sel_r;
  reg [3:0] sw_flags_r;
  reg [15:0] act_vel_r;
  reg fault_lat_r;
  reg fault_s1_r;
  reg fault_s2_r;
  reg [15:0] cmd_r;
  reg [15:0] ref_r;
  reg [15:0] req_addr_r;
  reg [15:0] req_code_r;
  reg [15:0] req_hi_r;
  reg [15:0] req_lo_r;
  reg [3:0] pa_state_r;
  reg [3:0] pa_state_nxt;
  reg [15:0] pa_code_r;
  reg [15:0] pa_code_nxt;
  reg [31:0] pa_wdata_r;
  reg [31:0] pa_wdata_nxt;
  reg [IW-1:0] pa_idx_r;
  reg [IW-1:0] pa_idx_nxt;
  reg [15:0] pa_rsp_r;
  reg [15:0] pa_rsp_nxt;
  reg [31:0] pa_val_r;
  reg [31:0] pa_val_nxt;
  reg [4:0] ds_r;
  reg [4:0] ds_nxt;
  reg freset_d_r;
  reg [15:0] tel_prev_r;
  reg [15:0] state_word;
  reg [31:0] rd_mux;
  reg st_wr;
  reg st_rd;
  reg st_wide;

  wire param_en = param_tel(tel_sel_r);
  wire profile_en = (tel_sel_r == `DCP_TEL_BASIC) || param_en;
  wire bus_req = avs_read | avs_write;
  wire wr_take = avs_write & ~avs_waitrequest;
  wire [15:0] addr_ofs = req_addr_r - `DCP_PARAM_BASE;
  wire addr_ok = (req_addr_r >= `DCP_PARAM_BASE) && (addr_ofs < DEPTH);
  wire fault_src = fault_s2_r | fault_lat_r;
  wire freset_edge = cmd_r[`DCP_CW_FRESET] & ~freset_d_r;
  wire sw_fault_set = wr_take && (avs_address == `DCP_OFS_DRV_FLAGS) && avs_byteenable[0] &&
                      avs_writedata[`DCP_FL_FAULT];
  wire tel_changed = (tel_sel_r != tel_prev_r);
  wire [31:0] st_rdata;
  wire st_rwide;
  wire [31:0] tel_merged = merge_be({16'h0000, tel_sel_r}, avs_writedata, avs_byteenable);
  wire [31:0] vel_merged = merge_be({16'h0000, act_vel_r}, avs_writedata, avs_byteenable);

  dcp_param_store #(
    .IW(IW),
    .DEPTH(DEPTH)
  ) u_store (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wr_en(st_wr),
    .rd_en(st_rd),
    .idx(pa_idx_r),
    .wr_data(pa_wdata_r),
    .wr_wide(st_wide),
    .rd_data(st_rdata),
    .rd_wide(st_rwide)
  );

  // avalon slave, one wait cycle per access
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      tel_sel_r <= `DCP_TEL_RESET;
      sw_flags_r <= 4'h0;
      act_vel_r <= 16'h0000;
    end else begin
      if (bus_req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= rd_mux;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (wr_take) begin
        case (avs_address)
          `DCP_OFS_TEL_SEL: begin
            tel_sel_r <= tel_merged[15:0];
          end
          `DCP_OFS_DRV_FLAGS: begin
            if (avs_byteenable[0]) begin
              sw_flags_r <= {avs_writedata[3:1], 1'b0};
            end
          end
          `DCP_OFS_ACT_VEL: begin
            act_vel_r <= vel_merged[15:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  always @* begin
    case (avs_address)
      `DCP_OFS_TEL_SEL: rd_mux = {16'h0000, tel_sel_r};
      `DCP_OFS_DRV_FLAGS: rd_mux = {28'h0000000, sw_flags_r[3:1], fault_src};
      `DCP_OFS_ACT_VEL: rd_mux = {16'h0000, act_vel_r};
      `DCP_OFS_STATUS: rd_mux = {7'h00, pa_state_r, ds_r, state_word};
      `DCP_OFS_CMD_VIEW: rd_mux = {ref_r, cmd_r};
      `DCP_OFS_PARAM_VIEW: rd_mux = {pa_rsp_r, req_addr_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // cyclic frame capture
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      cmd_r <= 16'h0000;
      ref_r <= 16'h0000;
      req_addr_r <= 16'h0000;
      req_code_r <= `DCP_REQ_NONE;
      req_hi_r <= 16'h0000;
      req_lo_r <= 16'h0000;
      tel_prev_r <= `DCP_TEL_RESET;
    end else begin
      tel_prev_r <= tel_sel_r;
      if (rx_valid && profile_en) begin
        cmd_r <= rx_command_word;
        ref_r <= rx_speed_reference_word;
      end
      if (rx_valid && param_en) begin
        req_addr_r <= rx_param_address_word;
        req_code_r <= rx_req_code;
        req_hi_r <= rx_param_value_word_hi;
        req_lo_r <= rx_param_value_word_lo;
      end
    end
  end

  // parameter request handler
  always @* begin
    pa_state_nxt = pa_state_r;
    pa_code_nxt = pa_code_r;
    pa_wdata_nxt = pa_wdata_r;
    pa_idx_nxt = pa_idx_r;
    pa_rsp_nxt = pa_rsp_r;
    pa_val_nxt = pa_val_r;
    st_wr = 1'b0;
    st_rd = 1'b0;
    st_wide = 1'b0;
    case (pa_state_r)
      PA_IDLE: begin
        pa_rsp_nxt = `DCP_RSP_NONE;
        pa_val_nxt = 32'h0000_0000;
        if (param_en && (req_code_r != `DCP_REQ_NONE)) begin
          pa_code_nxt = req_code_r;
          pa_idx_nxt = addr_ofs[IW-1:0];
          // word three only with 32-bit write
          if (req_code_r == `DCP_REQ_WR32) begin
            pa_wdata_nxt = {req_hi_r, req_lo_r};
          end else begin
            pa_wdata_nxt = {16'h0000, req_lo_r};
          end
          if (!addr_ok || (req_code_r > `DCP_REQ_WR32)) begin
            pa_rsp_nxt = `DCP_RSP_ERR;
            pa_state_nxt = PA_DONE;
          end else begin
            pa_rsp_nxt = `DCP_RSP_BUSY;
            pa_state_nxt = PA_BUSY;
          end
        end
      end
      PA_BUSY: begin
        st_wr = (pa_code_r != `DCP_REQ_READ);
        st_rd = (pa_code_r == `DCP_REQ_READ);
        st_wide = (pa_code_r == `DCP_REQ_WR32);
        pa_state_nxt = PA_WAIT;
      end
      PA_WAIT: begin
        if (pa_code_r == `DCP_REQ_READ) begin
          pa_rsp_nxt = st_rwide ? `DCP_RSP_RD32 : `DCP_RSP_RD16;
          pa_val_nxt = st_rwide ? st_rdata : {16'h0000, st_rdata[15:0]};
        end else begin
          pa_rsp_nxt = (pa_code_r == `DCP_REQ_WR32) ? `DCP_RSP_WR32 : `DCP_RSP_WR16;
          pa_val_nxt = pa_wdata_r;
        end
        pa_state_nxt = PA_DONE;
      end
      PA_DONE: begin
        if (req_code_r == `DCP_REQ_NONE) begin
          pa_rsp_nxt = `DCP_RSP_NONE;
          pa_val_nxt = 32'h0000_0000;
          pa_state_nxt = PA_IDLE;
        end
      end
      default: begin
        pa_state_nxt = PA_IDLE;
      end
    endcase
    if (!param_en || tel_changed) begin
      pa_state_nxt = PA_IDLE;
      pa_rsp_nxt = `DCP_RSP_NONE;
      pa_val_nxt = 32'h0000_0000;
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pa_state_r <= PA_IDLE;
      pa_code_r <= `DCP_REQ_NONE;
      pa_wdata_r <= 32'h0000_0000;
      pa_idx_r <= {IW{1'b0}};
      pa_rsp_r <= `DCP_RSP_NONE;
      pa_val_r <= 32'h0000_0000;
    end else begin
      pa_state_r <= pa_state_nxt;
      pa_code_r <= pa_code_nxt;
      pa_wdata_r <= pa_wdata_nxt;
      pa_idx_r <= pa_idx_nxt;
      pa_rsp_r <= pa_rsp_nxt;
      pa_val_r <= pa_val_nxt;
    end
  end

  // fault pin synchroniser and latch
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      fault_s1_r <= 1'b0;
      fault_s2_r <= 1'b0;
      fault_lat_r <= 1'b0;
      freset_d_r <= 1'b0;
    end else begin
      fault_s1_r <= drive_fault_in;
      fault_s2_r <= fault_s1_r;
      freset_d_r <= cmd_r[`DCP_CW_FRESET];
      // reset on rising edge, set wins
      if (sw_fault_set || fault_s2_r) begin
        fault_lat_r <= 1'b1;
      end else if (freset_edge) begin
        fault_lat_r <= 1'b0;
      end
    end
  end

  // drive state machine
  always @* begin
    ds_nxt = ds_r;
    case (ds_r)
      DS_INHIB: begin
        if (cmd_r[`DCP_CW_NO_COAST] && cmd_r[`DCP_CW_NO_QSTOP] && !cmd_r[`DCP_CW_ON]) begin
          ds_nxt = DS_READY;
        end
      end
      DS_READY: begin
        if (!cmd_r[`DCP_CW_NO_COAST] || !cmd_r[`DCP_CW_NO_QSTOP]) begin
          ds_nxt = DS_INHIB;
        end else if (cmd_r[`DCP_CW_ON]) begin
          ds_nxt = DS_SWON;
        end
      end
      DS_SWON: begin
        if (!cmd_r[`DCP_CW_NO_COAST] || !cmd_r[`DCP_CW_NO_QSTOP]) begin
          ds_nxt = DS_INHIB;
        end else if (!cmd_r[`DCP_CW_ON]) begin
          ds_nxt = DS_READY;
        end else if (cmd_r[`DCP_CW_ENABLE]) begin
          ds_nxt = DS_OPEN;
        end
      end
      DS_OPEN: begin
        if (!cmd_r[`DCP_CW_NO_COAST] || !cmd_r[`DCP_CW_NO_QSTOP]) begin
          ds_nxt = DS_INHIB;
        end else if (!cmd_r[`DCP_CW_ON]) begin
          ds_nxt = DS_READY;
        end else if (!cmd_r[`DCP_CW_ENABLE]) begin
          ds_nxt = DS_SWON;
        end
      end
      DS_FAULT: begin
        if (freset_edge && !fault_s2_r && !sw_fault_set) begin
          ds_nxt = DS_INHIB;
        end
      end
      default: begin
        ds_nxt = DS_INHIB;
      end
    endcase
    if (fault_src && (ds_r != DS_FAULT)) begin
      ds_nxt = DS_FAULT;
    end
  end

  always @* begin
    state_word = 16'h0000;
    state_word[0] = (ds_r == DS_READY) || (ds_r == DS_SWON) || (ds_r == DS_OPEN);
    state_word[1] = (ds_r == DS_SWON) || (ds_r == DS_OPEN);
    state_word[2] = (ds_r == DS_OPEN);
    state_word[3] = (ds_r == DS_FAULT);
    state_word[4] = cmd_r[`DCP_CW_NO_COAST];
    state_word[5] = cmd_r[`DCP_CW_NO_QSTOP];
    state_word[6] = (ds_r == DS_INHIB);
    state_word[7] = sw_flags_r[`DCP_FL_WARN];
    state_word[8] = sw_flags_r[`DCP_FL_SPD_TOL];
    state_word[9] = cmd_r[`DCP_CW_BUS_CTRL];
    state_word[10] = sw_flags_r[`DCP_FL_FREQ_OK];
  end

  // response and profile outputs
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ds_r <= DS_INHIB;
      tx_param_address_word <= 16'h0000;
      tx_resp_code <= `DCP_RSP_NONE;
      tx_param_value_word_hi <= 16'h0000;
      tx_param_value_word_lo <= 16'h0000;
      tx_operating_state_word <= 16'h0000;
      tx_actual_velocity_word <= 16'h0000;
      run_enable <= 1'b0;
      speed_setpoint <= 16'h0000;
    end else begin
      ds_r <= ds_nxt;
      tx_param_address_word <= param_en ? req_addr_r : 16'h0000;
      tx_resp_code <= pa_rsp_r;
      if ((pa_rsp_r == `DCP_RSP_RD32) || (pa_rsp_r == `DCP_RSP_WR32)) begin
        tx_param_value_word_hi <= pa_val_r[31:16];
      end else begin
        tx_param_value_word_hi <= 16'h0000;
      end
      tx_param_value_word_lo <= pa_val_r[15:0];
      tx_operating_state_word <= profile_en ? state_word : 16'h0000;
      tx_actual_velocity_word <= profile_en ? act_vel_r : 16'h0000;
      run_enable <= (ds_r == DS_OPEN);
      if ((ds_r == DS_OPEN) && cmd_r[`DCP_CW_BUS_CTRL]) begin
        speed_setpoint <= ref_r;
      end else begin
        speed_setpoint <= 16'h0000;
      end
    end
  end
endmodule

//--- src/dcp_map.vh
// constants of the cyclic drive parameter access block
`ifndef DCP_MAP_VH
`define DCP_MAP_VH
`define DCP_OFS_TEL_SEL 4'h0
`define DCP_OFS_DRV_FLAGS 4'h1
`define DCP_OFS_ACT_VEL 4'h2
`define DCP_OFS_STATUS 4'h3
`define DCP_OFS_CMD_VIEW 4'h4
`define DCP_OFS_PARAM_VIEW 4'h5
`define DCP_TEL_RESET 16'h0001
`define DCP_TEL_BASIC 16'h0001
`define DCP_TEL_P100 16'h0064
`define DCP_TEL_P101 16'h0065
`define DCP_TEL_P102 16'h0066
`define DCP_TEL_P106 16'h006a
`define DCP_TEL_P107 16'h006b
`define DCP_REQ_NONE 16'h0000
`define DCP_REQ_READ 16'h0001
`define DCP_REQ_WR16 16'h0002
`define DCP_REQ_WR32 16'h0003
`define DCP_RSP_NONE 16'h0000
`define DCP_RSP_RD16 16'h0001
`define DCP_RSP_WR16 16'h0002
`define DCP_RSP_BUSY 16'h0003
`define DCP_RSP_RD32 16'h0004
`define DCP_RSP_WR32 16'h0005
`define DCP_RSP_ERR 16'h0007
`define DCP_CW_ON 0
`define DCP_CW_NO_COAST 1
`define DCP_CW_NO_QSTOP 2
`define DCP_CW_ENABLE 3
`define DCP_CW_FRESET 7
`define DCP_CW_BUS_CTRL 10
`define DCP_FL_FAULT 0
`define DCP_FL_WARN 1
`define DCP_FL_SPD_TOL 2
`define DCP_FL_FREQ_OK 3
`define DCP_PARAM_BASE 16'h2328
`define DCP_PARAM_DEPTH 16
`endif

//--- src/dcp_param_store.v
// parameter storage array with per-entry width flag
`timescale 1ns/1ps
module dcp_param_store #(
  parameter IW = 4,
  parameter DEPTH = 16
) (
  input wire clk_sys, // system clock
  input wire sys_rst, // synchronous reset, high
  input wire wr_en, // write strobe
  input wire rd_en, // read strobe
  input wire [IW-1:0] idx, // entry index
  input wire [31:0] wr_data, // value to store
  input wire wr_wide, // value is 32 bit
  output reg [31:0] rd_data, // registered read value
  output reg rd_wide // registered width flag
);
  reg [31:0] mem [0:DEPTH-1];
  reg wide_mem [0:DEPTH-1];
  integer i;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= 32'h0000_0000;
        wide_mem[i] <= 1'b0;
      end
      rd_data <= 32'h0000_0000;
      rd_wide <= 1'b0;
    end else begin
      if (wr_en) begin
        mem[idx] <= wr_data;
        wide_mem[idx] <= wr_wide;
      end
      if (rd_en) begin
        rd_data <= mem[idx];
        rd_wide <= wide_mem[idx];
      end
    end
  end
endmodule

//--- tb/dcp_drive_param_asserts.sv
// port assertions for the cyclic drive block
`timescale 1ns/1ps
module dcp_chk (
  input wire clk_sys, // clock
  input wire sys_rst, // reset
  input wire avs_read, // bus read
  input wire avs_write, // bus write
  input wire avs_waitrequest, // bus stall
  input wire [15:0] tx_resp_code, // word two
  input wire [15:0] tx_param_value_word_hi, // word three
  input wire [15:0] tx_param_value_word_lo, // word four
  input wire run_enable, // power on
  input wire [15:0] speed_setpoint // speed out
);
  wire done_c = tx_resp_code inside {16'h1, 16'h2, 16'h4, 16'h5};
  wire wide_c = tx_resp_code inside {16'h4, 16'h5};
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answered;
    s_taken ##1 !avs_waitrequest;
  endsequence
  bus_answer_a: assert property (s_taken |=> !avs_waitrequest)
    else $error("bus access not answered");
  bus_single_a: assert property (s_answered |=> avs_waitrequest)
    else $error("stall low too long");
  reset_quiet_a: assert property ($past(sys_rst) |-> avs_waitrequest && tx_resp_code == 16'h0)
    else $error("outputs not quiet after reset");
  code_legal_a: assert property (tx_resp_code <= 16'h5 || tx_resp_code == 16'h7)
    else $error("illegal response code");
  busy_first_a: assert property
    ($changed(tx_resp_code) && done_c |-> $past(tx_resp_code) == 16'h3)
    else $error("result without busy");
  hold_final_a: assert property
    (done_c |=> tx_resp_code == $past(tx_resp_code) || tx_resp_code == 16'h0)
    else $error("result not held");
  wide_only_a: assert property (!wide_c |-> tx_param_value_word_hi == 16'h0)
    else $error("word three used");
  err_zero_a: assert property (tx_resp_code == 16'h7 |-> tx_param_value_word_lo == 16'h0)
    else $error("value on error");
  stop_zero_a: assert property ($fell(run_enable) |-> ##[0:1] speed_setpoint == 16'h0)
    else $error("speed kept after disable");
endmodule

//--- tb/dcp_plc_model.sv
// controller model sending cyclic request frames
`timescale 1ns/1ps
module dcp_plc_model (
  input wire clk_sys, // clock
  output reg rx_valid, // frame strobe
  output reg [15:0] rx_param_address_word, // word one
  output reg [15:0] rx_req_code, // word two
  output reg [15:0] rx_param_value_word_hi, // word three
  output reg [15:0] rx_param_value_word_lo, // word four
  output reg [15:0] rx_command_word, // command
  output reg [15:0] rx_speed_reference_word // reference
);
  integer gap = 2;
  initial begin
    rx_valid = 1'b0;
    {rx_param_address_word, rx_req_code, rx_param_value_word_hi} = 48'h0;
    {rx_param_value_word_lo, rx_command_word, rx_speed_reference_word} = 48'h0;
  end
  task send(input [15:0] a, c, h, l, cw, sr);
    begin
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      {rx_param_address_word, rx_req_code, rx_param_value_word_hi} <= {a, c, h};
      {rx_param_value_word_lo, rx_command_word, rx_speed_reference_word} <= {l, cw, sr};
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      // stale words after the strobe
      {rx_param_address_word, rx_req_code, rx_param_value_word_hi} <= ~{a, c, h};
      {rx_param_value_word_lo, rx_command_word, rx_speed_reference_word} <= ~{l, cw, sr};
      repeat (gap) @(posedge clk_sys);
    end
  endtask
endmodule

//--- tb/tb_dcp_drive_param.sv
// self-checking bench for the cyclic drive block
`timescale 1ns/1ps
`include "dcp_map.vh"
module tb_dcp_drive_param;
  localparam [15:0] ref_w = 16'h0321;
  reg clk_sys = 1'b0;
  reg sys_rst = 1'b1;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0, avs_write = 1'b0, drive_fault_in = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [3:0] avs_byteenable = 4'hf;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, rx_valid, run_enable;
  wire [15:0] rx_param_address_word, rx_req_code, rx_param_value_word_hi;
  wire [15:0] rx_param_value_word_lo, rx_command_word, rx_speed_reference_word;
  wire [15:0] tx_param_address_word, tx_resp_code, tx_param_value_word_hi;
  wire [15:0] tx_param_value_word_lo, tx_operating_state_word, tx_actual_velocity_word;
  wire [15:0] speed_setpoint;
  integer miscompares = 0;
  integer cmp_count = 0;
  reg [31:0] rd;
  reg [15:0] cmd = 16'h0;
  reg seen_busy = 1'b0;

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (tx_resp_code === 16'h3) seen_busy <= 1'b1;

  dcp_drive_param dut_u (.clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_valid,
    .rx_param_address_word, .rx_req_code, .rx_param_value_word_hi, .rx_param_value_word_lo,
    .rx_command_word, .rx_speed_reference_word, .tx_param_address_word, .tx_resp_code,
    .tx_param_value_word_hi, .tx_param_value_word_lo, .tx_operating_state_word,
    .tx_actual_velocity_word, .drive_fault_in, .run_enable, .speed_setpoint);
  dcp_plc_model u_plc (.clk_sys, .rx_valid, .rx_param_address_word, .rx_req_code,
    .rx_param_value_word_hi, .rx_param_value_word_lo, .rx_command_word,
    .rx_speed_reference_word);

  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task give_verdict;
    begin
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // one bus access, held until the stall drops
  task av(input wr, input [3:0] a, input [31:0] d, input [3:0] be);
    begin
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask

  task tel(input [15:0] t);
    begin
      av(1'b1, `DCP_OFS_TEL_SEL, {16'h0, t}, 4'hf);
      u_plc.send(16'h0, `DCP_REQ_NONE, 16'h0, 16'h0, cmd, ref_w);
    end
  endtask

  task prof(input [15:0] c, m, ex, input run, input [15:0] sp);
    begin
      cmd = c;
      u_plc.send(16'h0, 16'h0, 16'h0, 16'h0, c, ref_w);
      repeat (4) @(posedge clk_sys);
      check(tx_operating_state_word & m, ex);
      check(run_enable, run);
      check(speed_setpoint, sp);
    end
  endtask

  task preq(input [15:0] a, c, h, l, ec, eh, el);
    integer n;
    begin
      seen_busy = 1'b0;
      n = 0;
      u_plc.send(a, c, h, l, cmd, ref_w);
      while (n < 30 && !(tx_resp_code inside {16'h1, 16'h2, 16'h4, 16'h5, 16'h7})) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      check(tx_resp_code, ec);
      check(tx_param_value_word_hi, eh);
      check(tx_param_value_word_lo, el);
      check(tx_param_address_word, (ec == 16'h0) ? 16'h0 : a);
      check(seen_busy, ec != 16'h0 && ec != 16'h7);
      // a fresh request before clearing must not be taken
      u_plc.send(a + 16'h1, 16'h1, h, l, cmd, ref_w);
      repeat (4) @(posedge clk_sys);
      check(tx_resp_code, ec);
      u_plc.send(a, 16'h0, h, l, cmd, ref_w);
      repeat (4) @(posedge clk_sys);
      check(tx_resp_code, 16'h0);
    end
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    av(1'b0, `DCP_OFS_TEL_SEL, 32'h0, 4'hf);
    check(rd, 32'h1);
    av(1'b1, 4'hf, 32'hffff_ffff, 4'hf);
    av(1'b0, 4'hf, 32'h0, 4'hf);
    check(rd, 32'h0);
    preq(16'h2328, 16'h2, 16'h0, 16'h5555, 16'h0, 16'h0, 16'h0);
    prof(16'h0006, 16'h0077, 16'h0031, 1'b0, 16'h0);
    prof(16'h0007, 16'h0077, 16'h0033, 1'b0, 16'h0);
    prof(16'h040f, 16'h0077, 16'h0037, 1'b1, ref_w);
    prof(16'h0407, 16'h0077, 16'h0033, 1'b0, 16'h0);
    prof(16'h000f, 16'h0077, 16'h0037, 1'b1, 16'h0);
    prof(16'h0405, 16'h0077, 16'h0060, 1'b0, 16'h0);
    av(1'b1, `DCP_OFS_ACT_VEL, 32'h1234, 4'hf);
    av(1'b1, `DCP_OFS_ACT_VEL, 32'hffff_ffab, 4'h1);
    av(1'b0, `DCP_OFS_ACT_VEL, 32'h0, 4'hf);
    check(rd, 32'h12ab);
    check(tx_actual_velocity_word, 16'h12ab);
    prof(16'h0006, 16'h0048, 16'h0000, 1'b0, 16'h0);
    drive_fault_in <= 1'b1;
    prof(16'h0006, 16'h0008, 16'h0008, 1'b0, 16'h0);
    prof(16'h0086, 16'h0008, 16'h0008, 1'b0, 16'h0);
    drive_fault_in <= 1'b0;
    prof(16'h0086, 16'h0008, 16'h0008, 1'b0, 16'h0);
    prof(16'h0006, 16'h0008, 16'h0008, 1'b0, 16'h0);
    prof(16'h0084, 16'h0048, 16'h0040, 1'b0, 16'h0);
    av(1'b0, `DCP_OFS_STATUS, 32'h0, 4'hf);
    check(rd[15:0] & 16'h0048, 16'h0040);
    av(1'b1, `DCP_OFS_DRV_FLAGS, 32'he, 4'hf);
    prof(16'h0484, 16'h0788, 16'h0780, 1'b0, 16'h0);
    av(1'b0, `DCP_OFS_DRV_FLAGS, 32'h0, 4'hf);
    check(rd, 32'he);
    av(1'b0, `DCP_OFS_CMD_VIEW, 32'h0, 4'hf);
    check(rd, {ref_w, 16'h0484});
    av(1'b1, `DCP_OFS_DRV_FLAGS, 32'h1, 4'hf);
    prof(16'h0404, 16'h0788, 16'h0208, 1'b0, 16'h0);
    av(1'b0, `DCP_OFS_DRV_FLAGS, 32'h0, 4'hf);
    check(rd, 32'h1);
    prof(16'h0484, 16'h0048, 16'h0040, 1'b0, 16'h0);
    tel(`DCP_TEL_P100);
    preq(16'h2328, 16'h3, 16'h1234, 16'h5678, 16'h5, 16'h1234, 16'h5678);
    tel(`DCP_TEL_P101);
    preq(16'h2328, 16'h1, 16'h0, 16'h0, 16'h4, 16'h1234, 16'h5678);
    tel(`DCP_TEL_P102);
    preq(16'h2337, 16'h2, 16'h7777, 16'habcd, 16'h2, 16'h0, 16'habcd);
    tel(`DCP_TEL_P106);
    u_plc.gap = 20;
    preq(16'h2337, 16'h1, 16'h0, 16'h0, 16'h1, 16'h0, 16'habcd);
    u_plc.gap = 2;
    tel(`DCP_TEL_P107);
    preq(16'h2338, 16'h1, 16'h0, 16'h0, 16'h7, 16'h0, 16'h0);
    preq(16'h2328, 16'h4, 16'h0, 16'h0, 16'h7, 16'h0, 16'h0);
    av(1'b0, `DCP_OFS_PARAM_VIEW, 32'h0, 4'hf);
    check(rd, 32'h0000_2328);
    tel(16'h0005);
    check(tx_operating_state_word, 16'h0);
    check(tx_param_address_word, 16'h0);
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares = miscompares + 1;
    give_verdict;
  end
endmodule

bind dcp_drive_param dcp_chk u_chk (.clk_sys, .sys_rst, .avs_read, .avs_write,
  .avs_waitrequest, .tx_resp_code, .tx_param_value_word_hi, .tx_param_value_word_lo,
  .run_enable, .speed_setpoint);
